// file: hw/omd_params.svh
// omd_params.svh: offsets, field positions, reset values and ranges
// assumes: included by bare name from the omd design files
// Functional notes
// - flags bit 0 picks set-1 register bank
// - bank-0 op clears, bank-1 op sets flag
// - each flag follows its per-instruction effect class
// - working register 0-15 via pointer, bit 0-7
// - bit-0 operand touches only bit 0
// - general register 0-255 or working 0-15
// - working pair only even 0 to 14
// - register pair: working pair or even 0-254
// - call vector even 0-254, target fetched there
// - indirect through working or full register contents
// - indirect working pair: even pair only
// - indexed register: base plus working register
// - short index: signed 8-bit offset plus pair
// - long index: 16-bit offset plus pair
// - direct mode carries full 16-bit address
// - relative: signed offset plus next address
// - immediate byte literal 0-255
// - immediate word literal 0-65535
// - eight-bit flags; writes dropped when flags updated
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH

`define OMD_FLAGS_ADDR  8'hD5
`define OMD_FLAGS_RST   8'h00
`define OMD_FLAGS_W     8
`define OMD_BANK_BIT    0
`define OMD_FIS_BIT     1
`define OMD_HALF_BIT    2
`define OMD_DEC_BIT     3
`define OMD_OVF_BIT     4
`define OMD_SIGN_BIT    5
`define OMD_ZERO_BIT    6
`define OMD_CARRY_BIT   7
`define OMD_WREG_W      4
`define OMD_BIT_W       3
`define OMD_ADDR_W      8
`define OMD_WORD_W      16
`define OMD_PAIR_LSB    0

`endif

// file: hw/omd_pkg.sv
// omd_pkg: operand mode and flag effect class types
// assumes: nothing
package omd_pkg;

  typedef enum logic [4:0] {
    OMD_WREG, OMD_WREG_BIT, OMD_WREG_BIT0, OMD_GREG, OMD_GREG_BIT,
    OMD_WPAIR, OMD_RPAIR, OMD_CALL_VEC, OMD_IND_WREG, OMD_IND_GREG,
    OMD_IND_WPAIR, OMD_IND_RPAIR, OMD_INDEX_REG, OMD_SHORT_IDX,
    OMD_LONG_IDX, OMD_DIRECT, OMD_RELATIVE, OMD_IMM_BYTE, OMD_IMM_WORD
  } omd_mode_t;

  typedef enum logic [2:0] {
    OMD_FC_ZERO, OMD_FC_ONE, OMD_FC_CALC, OMD_FC_KEEP, OMD_FC_UNDEF
  } omd_fclass_t;

endpackage : omd_pkg

// file: hw/omd_flag_merge.sv
// omd_flag_merge: per-bit flag result from effect class
// assumes: classes and computed values valid with the update strobe
`timescale 1ns/10ps
`default_nettype none
module omd_flag_merge #(
  parameter int N = 8
) (
  // inputs
  input  wire logic [N-1:0]        prev_i,
  input  wire logic [N-1:0]        calc_i,
  input  wire omd_pkg::omd_fclass_t cls_i [N],
  // result
  output logic      [N-1:0]        next_o
);

  for (genvar g = 0; g < N; g++) begin : g_bit
    always_comb begin
      unique case (cls_i[g])
        omd_pkg::OMD_FC_ZERO: next_o[g] = 1'b0;
        omd_pkg::OMD_FC_ONE:  next_o[g] = 1'b1;
        omd_pkg::OMD_FC_CALC: next_o[g] = calc_i[g];
        default:              next_o[g] = prev_i[g];
      endcase
    end
  end

endmodule : omd_flag_merge
`default_nettype wire

// file: hw/omd_addr_add.sv
// omd_addr_add: address adder with optional 8-bit sign extension
// assumes: purely combinational, wraps at 16 bits
`timescale 1ns/10ps
`default_nettype none
module omd_addr_add #(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0] base_i,
  input  wire logic [W-1:0] offs_i,
  input  wire logic         sext8_i,
  // sum
  output logic      [W-1:0] sum_o
);

  logic [W-1:0] offs_x;

  always_comb begin
    if (sext8_i) begin
      offs_x = {{(W-8){offs_i[7]}}, offs_i[7:0]};
    end else begin
      offs_x = offs_i;
    end
    sum_o = base_i + offs_x;
  end

endmodule : omd_addr_add
`default_nettype wire

// file: hw/omd_operand_decode.sv
// omd_operand_decode: operand mode resolver and flags register
// assumes: one request per cycle, fields and contents stable with it
`timescale 1ns/10ps
`default_nettype none
`include "omd_params.svh"
module omd_operand_decode (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  // operand request
  input  wire logic                  dec_valid_i,
  input  wire omd_pkg::omd_mode_t    mode_i,
  input  wire logic [3:0]            wreg_i,
  input  wire logic [2:0]            bit_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic                  use_wreg_i,
  input  wire logic [15:0]           field_i,
  // operand contents and core state
  input  wire logic [7:0]            rp_base_i,
  input  wire logic [7:0]            reg_data_i,
  input  wire logic [15:0]           pair_data_i,
  input  wire logic [15:0]           next_pc_i,
  // flag control
  input  wire logic                  sel_lower_i,
  input  wire logic                  sel_upper_i,
  input  wire logic                  flag_upd_i,
  input  wire logic [7:0]            flag_calc_i,
  input  wire omd_pkg::omd_fclass_t  flag_cls_i [8],
  // register file write port
  input  wire logic                  rf_wr_i,
  input  wire logic [7:0]            rf_waddr_i,
  input  wire logic [7:0]            rf_wdata_i,
  // decode result
  output logic                       res_valid_o,
  output logic                       res_illegal_o,
  output logic                       reg_acc_o,
  output logic [7:0]                 reg_addr_o,
  output logic [7:0]                 bit_mask_o,
  output logic                       mem_acc_o,
  output logic [15:0]                mem_addr_o,
  output logic                       vec_fetch_o,
  output logic                       pc_load_o,
  output logic [15:0]                target_o,
  output logic                       imm_valid_o,
  output logic [15:0]                operand_o,
  // status
  output logic [7:0]                 flags_o,
  output logic                       bank_sel_o
);

  ////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic rst_n;
  assign rst_n = rst_s2_q;

  ////////////////////////////////////////////////////////////////////
  // flags register

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] flags_merged;
  logic       flags_hit;

  omd_flag_merge #(
    .N      (`OMD_FLAGS_W)
  ) u_merge (
    .prev_i (flags_q),
    .calc_i (flag_calc_i),
    .cls_i  (flag_cls_i),
    .next_o (flags_merged)
  );

  assign flags_hit = rf_wr_i && (rf_waddr_i == `OMD_FLAGS_ADDR);

  always_comb begin
    flags_d = flags_q;
    if (flag_upd_i) begin
      flags_d = flags_merged;
    end else if (flags_hit) begin
      flags_d = rf_wdata_i;
    end
    if (sel_lower_i) begin
      flags_d[`OMD_BANK_BIT] = 1'b0;
    end else if (sel_upper_i) begin
      flags_d[`OMD_BANK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `OMD_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_o    <= `OMD_FLAGS_RST;
      bank_sel_o <= 1'b0;
    end else begin
      flags_o    <= flags_d;
      bank_sel_o <= flags_d[`OMD_BANK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address helpers

  logic [7:0]  wreg_addr;
  logic [7:0]  wpair_addr;
  logic        wpair_odd;
  logic        rpair_odd;
  logic [15:0] add_base;
  logic [15:0] add_offs;
  logic        add_sext;
  logic [15:0] add_sum;

  assign wreg_addr  = {rp_base_i[7:4], wreg_i};
  assign wpair_addr = {rp_base_i[7:4], wreg_i};
  assign wpair_odd  = wreg_i[`OMD_PAIR_LSB];
  assign rpair_odd  = reg_addr_i[`OMD_PAIR_LSB];

  always_comb begin
    add_base = pair_data_i;
    add_offs = field_i;
    add_sext = 1'b0;
    unique case (mode_i)
      omd_pkg::OMD_INDEX_REG: begin
        add_base = {8'h00, reg_addr_i};
        add_offs = {8'h00, reg_data_i};
      end
      omd_pkg::OMD_SHORT_IDX: begin
        add_sext = 1'b1;
      end
      omd_pkg::OMD_RELATIVE: begin
        add_base = next_pc_i;
        add_sext = 1'b1;
      end
      default: begin
        add_sext = 1'b0;
      end
    endcase
  end

  omd_addr_add #(
    .W       (`OMD_WORD_W)
  ) u_add (
    .base_i  (add_base),
    .offs_i  (add_offs),
    .sext8_i (add_sext),
    .sum_o   (add_sum)
  );

  ////////////////////////////////////////////////////////////////////
  // mode decode

  logic        ill_d;
  logic        racc_d;
  logic [7:0]  raddr_d;
  logic [7:0]  mask_d;
  logic        macc_d;
  logic [15:0] maddr_d;
  logic        vec_d;
  logic        pcl_d;
  logic [15:0] tgt_d;
  logic        immv_d;
  logic [15:0] opnd_d;
  logic [7:0]  greg_addr;

  assign greg_addr = use_wreg_i ? wreg_addr : reg_addr_i;

  always_comb begin
    ill_d   = 1'b0;
    racc_d  = 1'b0;
    raddr_d = 8'h00;
    mask_d  = 8'hFF;
    macc_d  = 1'b0;
    maddr_d = 16'h0000;
    vec_d   = 1'b0;
    pcl_d   = 1'b0;
    tgt_d   = 16'h0000;
    immv_d  = 1'b0;
    opnd_d  = 16'h0000;
    unique case (mode_i)
      omd_pkg::OMD_WREG: begin
        racc_d  = 1'b1;
        raddr_d = wreg_addr;
      end
      omd_pkg::OMD_WREG_BIT: begin
        racc_d  = 1'b1;
        raddr_d = wreg_addr;
        mask_d  = 8'h01 << bit_i;
      end
      omd_pkg::OMD_WREG_BIT0: begin
        racc_d  = 1'b1;
        raddr_d = wreg_addr;
        mask_d  = 8'h01;
      end
      omd_pkg::OMD_GREG: begin
        racc_d  = 1'b1;
        raddr_d = greg_addr;
      end
      omd_pkg::OMD_GREG_BIT: begin
        racc_d  = 1'b1;
        raddr_d = greg_addr;
        mask_d  = 8'h01 << bit_i;
      end
      omd_pkg::OMD_WPAIR: begin
        ill_d   = wpair_odd;
        racc_d  = !wpair_odd;
        raddr_d = wpair_addr;
      end
      omd_pkg::OMD_RPAIR: begin
        if (use_wreg_i) begin
          ill_d   = wpair_odd;
          raddr_d = wpair_addr;
        end else begin
          ill_d   = rpair_odd;
          raddr_d = reg_addr_i;
        end
        racc_d = !ill_d;
      end
      omd_pkg::OMD_CALL_VEC: begin
        ill_d   = rpair_odd;
        macc_d  = !rpair_odd;
        vec_d   = !rpair_odd;
        maddr_d = {8'h00, reg_addr_i};
      end
      omd_pkg::OMD_IND_WREG: begin
        racc_d  = 1'b1;
        raddr_d = reg_data_i;
      end
      omd_pkg::OMD_IND_GREG: begin
        racc_d  = 1'b1;
        raddr_d = reg_data_i;
      end
      omd_pkg::OMD_IND_WPAIR: begin
        ill_d   = wpair_odd;
        macc_d  = !wpair_odd;
        maddr_d = pair_data_i;
      end
      omd_pkg::OMD_IND_RPAIR: begin
        ill_d   = use_wreg_i ? wpair_odd : rpair_odd;
        macc_d  = !ill_d;
        maddr_d = pair_data_i;
      end
      omd_pkg::OMD_INDEX_REG: begin
        racc_d  = 1'b1;
        raddr_d = add_sum[7:0];
      end
      omd_pkg::OMD_SHORT_IDX: begin
        ill_d   = wpair_odd;
        macc_d  = !wpair_odd;
        maddr_d = add_sum;
      end
      omd_pkg::OMD_LONG_IDX: begin
        ill_d   = wpair_odd;
        macc_d  = !wpair_odd;
        maddr_d = add_sum;
      end
      omd_pkg::OMD_DIRECT: begin
        pcl_d = 1'b1;
        tgt_d = field_i;
      end
      omd_pkg::OMD_RELATIVE: begin
        pcl_d = 1'b1;
        tgt_d = add_sum;
      end
      omd_pkg::OMD_IMM_BYTE: begin
        immv_d = 1'b1;
        opnd_d = {8'h00, field_i[7:0]};
      end
      omd_pkg::OMD_IMM_WORD: begin
        immv_d = 1'b1;
        opnd_d = field_i;
      end
      default: begin
        ill_d = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // result registers

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_o   <= 1'b0;
      res_illegal_o <= 1'b0;
    end else begin
      res_valid_o   <= dec_valid_i;
      res_illegal_o <= dec_valid_i && ill_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_acc_o   <= 1'b0;
      mem_acc_o   <= 1'b0;
      vec_fetch_o <= 1'b0;
      pc_load_o   <= 1'b0;
      imm_valid_o <= 1'b0;
    end else begin
      reg_acc_o   <= dec_valid_i && racc_d;
      mem_acc_o   <= dec_valid_i && macc_d;
      vec_fetch_o <= dec_valid_i && vec_d;
      pc_load_o   <= dec_valid_i && pcl_d;
      imm_valid_o <= dec_valid_i && immv_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr_o <= 8'h00;
      bit_mask_o <= 8'h00;
      mem_addr_o <= 16'h0000;
      target_o   <= 16'h0000;
      operand_o  <= 16'h0000;
    end else if (dec_valid_i) begin
      reg_addr_o <= raddr_d;
      bit_mask_o <= mask_d;
      mem_addr_o <= maddr_d;
      target_o   <= tgt_d;
      operand_o  <= opnd_d;
    end
  end

endmodule : omd_operand_decode
`default_nettype wire

// file: sim/omd_operand_decode_asserts.sv
// omd_operand_decode_asserts: port-level checks of the operand decoder
// assumes: bound to omd_operand_decode, single clock domain
`timescale 1ns/10ps
`default_nettype none
module omd_operand_decode_asserts (
  // clock and reset
  input wire logic               mclk_i,
  input wire logic               rst_n_i,
  // stimulus
  input wire logic               dec_valid_i,
  input wire omd_pkg::omd_mode_t mode_i,
  input wire logic [3:0]         wreg_i,
  input wire logic [7:0]         reg_addr_i,
  input wire logic [15:0]        field_i,
  input wire logic [15:0]        pair_data_i,
  input wire logic [15:0]        next_pc_i,
  input wire logic               sel_lower_i,
  input wire logic               sel_upper_i,
  input wire logic               flag_upd_i,
  input wire logic               rf_wr_i,
  input wire logic [7:0]         rf_waddr_i,
  input wire logic [7:0]         rf_wdata_i,
  // results
  input wire logic               res_illegal_o,
  input wire logic               mem_acc_o,
  input wire logic [15:0]        mem_addr_o,
  input wire logic               vec_fetch_o,
  input wire logic               pc_load_o,
  input wire logic [15:0]        target_o,
  input wire logic               imm_valid_o,
  input wire logic [15:0]        operand_o,
  input wire logic [7:0]         flags_o,
  input wire logic               bank_sel_o
);
  logic [15:0] rel_sum;
  logic [15:0] lidx_sum;
  assign rel_sum  = next_pc_i + {{8{field_i[7]}}, field_i[7:0]};
  assign lidx_sum = pair_data_i + field_i;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_bank_upper: assert property (
    sel_upper_i && !sel_lower_i |=> bank_sel_o && flags_o[0]) else $error("upper bank not set");
  a_bank_lower: assert property (
    sel_lower_i && !sel_upper_i |=> !bank_sel_o && !flags_o[0]) else $error("bank not cleared");
  a_bank_mirror: assert property (
    bank_sel_o == flags_o[0]) else $error("bank output differs from flag bit");
  a_reset_clear: assert property (
    $rose(rst_n_i) |-> flags_o == 8'h00 && !bank_sel_o) else $error("flags not clear at reset");
  a_imm_byte: assert property (
    dec_valid_i && mode_i == omd_pkg::OMD_IMM_BYTE
    |=> imm_valid_o && operand_o == ($past(field_i) & 16'h00FF)) else $error("bad byte literal");
  a_rel_target: assert property (
    dec_valid_i && mode_i == omd_pkg::OMD_RELATIVE
    |=> pc_load_o && target_o == $past(rel_sum)) else $error("bad relative target");
  a_vec_odd: assert property (
    dec_valid_i && mode_i == omd_pkg::OMD_CALL_VEC && reg_addr_i[0]
    |=> res_illegal_o && !vec_fetch_o && !mem_acc_o) else $error("odd vector accepted");
  a_long_idx: assert property (
    dec_valid_i && mode_i == omd_pkg::OMD_LONG_IDX && !wreg_i[0]
    |=> mem_acc_o && mem_addr_o == $past(lidx_sum)) else $error("bad long index address");
  a_flag_write: assert property (
    rf_wr_i && rf_waddr_i == 8'hD5 && !flag_upd_i && !sel_lower_i && !sel_upper_i
    |=> flags_o == $past(rf_wdata_i)) else $error("flags write lost");
endmodule : omd_operand_decode_asserts

bind omd_operand_decode omd_operand_decode_asserts u_chk (.*);
`default_nettype wire

// file: sim/operand_mode_decode_bank_flag_tb_top.sv
// operand_mode_decode_bank_flag_tb_top: directed bench of the decoder
// assumes: omd_pkg and design files compiled first
`timescale 1ns/10ps
`default_nettype none
module operand_mode_decode_bank_flag_tb_top;
  logic mclk_i, rst_n_i, dec_valid_i, use_wreg_i, sel_lower_i, sel_upper_i;
  logic flag_upd_i, rf_wr_i;
  logic [3:0] wreg_i;
  logic [2:0] bit_i;
  logic [7:0] reg_addr_i, rp_base_i, reg_data_i, flag_calc_i, rf_waddr_i, rf_wdata_i;
  logic [15:0] field_i, pair_data_i, next_pc_i;
  omd_pkg::omd_mode_t mode_i;
  omd_pkg::omd_fclass_t flag_cls_i [8];
  logic res_valid_o, res_illegal_o, reg_acc_o, mem_acc_o, vec_fetch_o;
  logic pc_load_o, imm_valid_o, bank_sel_o;
  logic [7:0] reg_addr_o, bit_mask_o, flags_o;
  logic [15:0] mem_addr_o, target_o, operand_o;
  int errors, n_tests, cyc;

  omd_operand_decode dut (.*);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      close_out();
    end
  end

  task close_out;
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task dec(input omd_pkg::omd_mode_t m, input logic [3:0] w, input logic [7:0] a,
           input logic [15:0] f);
    @(negedge mclk_i);
    dec_valid_i = 1;
    mode_i = m;
    wreg_i = w;
    reg_addr_i = a;
    field_i = f;
    @(negedge mclk_i);
    dec_valid_i = 0;
  endtask : dec

  task fstep(input logic up, input logic lo, input logic upd, input logic [7:0] wd);
    @(negedge mclk_i);
    sel_upper_i = up;
    sel_lower_i = lo;
    flag_upd_i = upd;
    rf_wr_i = 1;
    rf_wdata_i = wd;
    @(negedge mclk_i);
    {sel_upper_i, sel_lower_i, flag_upd_i, rf_wr_i} = 4'h0;
  endtask : fstep

  task ill;
    chk({res_valid_o, res_illegal_o, reg_acc_o, mem_acc_o, vec_fetch_o}, 20'h18);
  endtask : ill

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, dec_valid_i, use_wreg_i, sel_lower_i, sel_upper_i, flag_upd_i, rf_wr_i} = 7'h0;
    {wreg_i, bit_i, reg_addr_i, field_i, flag_calc_i, rf_wdata_i} = '0;
    mode_i = omd_pkg::OMD_WREG;
    rf_waddr_i = 8'hD5;
    rp_base_i = 8'hC0;
    reg_data_i = 8'h20;
    pair_data_i = 16'hFFF0;
    next_pc_i = 16'h1000;
    foreach (flag_cls_i[i]) flag_cls_i[i] = omd_pkg::OMD_FC_KEEP;
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1;
    repeat (3) @(negedge mclk_i);
    chk({bank_sel_o, flags_o}, 20'h0);
    fstep(1, 0, 0, 8'h00);
    chk({bank_sel_o, flags_o[0]}, 20'h3);
    fstep(0, 1, 0, 8'hBD);
    chk(flags_o, 20'hBC);
    flag_cls_i[7] = omd_pkg::OMD_FC_ZERO;
    flag_cls_i[6] = omd_pkg::OMD_FC_ONE;
    flag_cls_i[5] = omd_pkg::OMD_FC_CALC;
    flag_cls_i[3] = omd_pkg::OMD_FC_UNDEF;
    fstep(0, 0, 1, 8'hFF);
    chk(flags_o & 8'hF7, 20'h54);
    fstep(0, 0, 0, 8'h01);
    chk({bank_sel_o, flags_o}, 20'h101);
    chk(bank_sel_o, 20'h1);
    rst_n_i = 0;
    repeat (2) @(negedge mclk_i);
    chk({bank_sel_o, flags_o}, 20'h0);
    rst_n_i = 1;
    repeat (3) @(negedge mclk_i);
    dec(omd_pkg::OMD_IMM_BYTE, 0, 0, 16'hAB42);
    chk({imm_valid_o, operand_o}, 20'h10042);
    dec(omd_pkg::OMD_IMM_WORD, 0, 0, 16'hBEEF);
    chk({imm_valid_o, operand_o}, 20'h1BEEF);
    dec(omd_pkg::OMD_DIRECT, 0, 0, 16'hFFFF);
    chk({res_valid_o, res_illegal_o}, 20'h2);
    chk({pc_load_o, target_o}, 20'h1FFFF);
    dec(omd_pkg::OMD_RELATIVE, 0, 0, 16'h0080);
    chk({pc_load_o, target_o}, 20'h10F80);
    dec(omd_pkg::OMD_RELATIVE, 0, 0, 16'h007F);
    chk({pc_load_o, target_o}, 20'h1107F);
    dec(omd_pkg::OMD_WREG, 4'hF, 0, 0);
    chk({reg_acc_o, reg_addr_o, bit_mask_o}, 20'h1CFFF);
    bit_i = 3'h7;
    dec(omd_pkg::OMD_WREG_BIT, 4'h3, 0, 0);
    chk({reg_addr_o, bit_mask_o}, 20'hC380);
    bit_i = 3'h5;
    dec(omd_pkg::OMD_WREG_BIT0, 4'h3, 0, 0);
    chk(bit_mask_o, 20'h01);
    dec(omd_pkg::OMD_GREG_BIT, 0, 8'hFF, 0);
    chk({reg_addr_o, bit_mask_o}, 20'hFF20);
    use_wreg_i = 1;
    rp_base_i = 8'hC8;
    dec(omd_pkg::OMD_GREG, 4'h7, 8'h55, 0);
    chk({reg_acc_o, reg_addr_o}, 20'h1C7);
    dec(omd_pkg::OMD_WPAIR, 4'h5, 0, 0);
    ill();
    dec(omd_pkg::OMD_WPAIR, 4'hE, 0, 0);
    chk({res_illegal_o, reg_addr_o}, 20'hCE);
    dec(omd_pkg::OMD_RPAIR, 4'h9, 0, 0);
    ill();
    use_wreg_i = 0;
    dec(omd_pkg::OMD_RPAIR, 0, 8'h33, 0);
    ill();
    dec(omd_pkg::OMD_RPAIR, 0, 8'hFE, 0);
    chk({res_illegal_o, reg_acc_o, reg_addr_o}, 20'h1FE);
    dec(omd_pkg::OMD_CALL_VEC, 0, 8'h01, 0);
    ill();
    dec(omd_pkg::OMD_CALL_VEC, 0, 8'hFE, 0);
    chk({vec_fetch_o, mem_addr_o}, 20'h100FE);
    dec(omd_pkg::OMD_IND_WREG, 4'h2, 0, 0);
    chk(reg_addr_o, 20'h20);
    dec(omd_pkg::OMD_IND_GREG, 0, 8'h40, 0);
    chk({reg_acc_o, reg_addr_o}, 20'h120);
    dec(omd_pkg::OMD_IND_WPAIR, 4'h3, 0, 0);
    ill();
    dec(omd_pkg::OMD_IND_WPAIR, 4'h4, 0, 0);
    chk({mem_acc_o, mem_addr_o}, 20'h1FFF0);
    dec(omd_pkg::OMD_IND_RPAIR, 0, 8'h11, 0);
    ill();
    dec(omd_pkg::OMD_IND_RPAIR, 0, 8'h10, 0);
    chk({mem_acc_o, mem_addr_o}, 20'h1FFF0);
    dec(omd_pkg::OMD_INDEX_REG, 4'h1, 8'hF0, 0);
    chk(reg_addr_o, 20'h10);
    dec(omd_pkg::OMD_LONG_IDX, 4'h2, 0, 16'h0020);
    chk({mem_acc_o, mem_addr_o}, 20'h10010);
    pair_data_i = 16'h0010;
    dec(omd_pkg::OMD_SHORT_IDX, 4'h2, 0, 16'h00FE);
    chk({mem_acc_o, mem_addr_o}, 20'h1000E);
    close_out();
  end
endmodule : operand_mode_decode_bank_flag_tb_top
`default_nettype wire
